// [design/cbs_pkg.sv]
package cbs_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W   = 16;
    localparam int DATA_W   = 8;
    localparam int STAT_W   = 8;
    localparam int CNT_W    = 24;
    localparam int TICK_BIT = 13;
    localparam int SW_W     = 16;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ      = 100;
    localparam int PHI_MHZ      = 2;
    localparam int POC_MS       = 100;
    localparam int RESET_US     = 33;
    localparam int PHI_HALF_CYC = CLK_MHZ / (PHI_MHZ * 2);
    localparam int POC_CYC      = POC_MS * 1000 * CLK_MHZ;
    localparam int RESET_CYC    = RESET_US * CLK_MHZ;
    localparam int PHI_CNT_W    = 6;
    localparam int POC_CNT_W    = 24;
    localparam int RST_CNT_W    = 12;

    // ==========================================================
    // Bus carrier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [STAT_W-1:0] status;
        logic [DATA_W-1:0] data_out;
    } cbs_sysbus_t;

    typedef enum logic [1:0] {
        CBS_SEL_NONE,
        CBS_SEL_BUS,
        CBS_SEL_PANEL
    } cbs_sel_t;

endpackage : cbs_pkg

// [design/cbs_cpu_glue.sv]
module cbs_cpu_glue
    import cbs_pkg::*;
#(
    parameter int POC_CYCLES = POC_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Processor side
    input  wire logic [ADDR_W-1:0] cpu_addr,
    input  wire logic [STAT_W-1:0] cpu_status,
    input  wire logic              cpu_status_valid,
    input  wire logic [DATA_W-1:0] cpu_data_o,
    input  wire logic              cpu_data_oe,
    output logic      [DATA_W-1:0] cpu_data_i,
    output logic                   cpu_data_i_oe,
    input  wire logic              data_in_strobe,
    output logic                   cpu_ready,
    output logic                   cpu_reset,
    // System bus
    output cbs_sysbus_t            sysbus,
    output logic      [DATA_W-1:0] bus_data_out,
    input  wire logic [DATA_W-1:0] bus_data_in,
    input  wire logic              bus_ready,
    output logic                   phi1,
    output logic                   phi2,
    output logic                   power_on_clear_n,
    // Front panel
    input  wire logic              panel_bus_control,
    input  wire logic [DATA_W-1:0] panel_data_in,
    input  wire logic [SW_W-1:0]   panel_switch_n,
    input  wire logic              clock_gen_ready_input,
    output logic                   counter_bit13_tick,
    output logic      [SW_W-1:0]   sw_stage2_q,
    output logic                   single_step_en,
    output logic                   run_stopped,
    output logic                   prom_addr_clear
);

    // ==========================================================
    // Input synchronisers (three stages, second and third agree)
    logic [2:0] bc_s_r;
    logic [2:0] rdy_s_r;
    logic [2:0] cgr_s_r;
    logic [2:0] stb_s_r;
    logic       bc_r;
    logic       rdy_r;
    logic       cgr_r;
    logic       stb_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bc_s_r  <= 3'h0;
            rdy_s_r <= 3'h0;
            cgr_s_r <= 3'h0;
            stb_s_r <= 3'h0;
        end else begin
            bc_s_r  <= {bc_s_r[1:0], panel_bus_control};
            rdy_s_r <= {rdy_s_r[1:0], bus_ready};
            cgr_s_r <= {cgr_s_r[1:0], clock_gen_ready_input};
            stb_s_r <= {stb_s_r[1:0], data_in_strobe};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bc_r  <= 1'b0;
            rdy_r <= 1'b0;
            cgr_r <= 1'b0;
            stb_r <= 1'b0;
        end else begin
            if (bc_s_r[1] == bc_s_r[2])
                bc_r <= bc_s_r[2];
            if (rdy_s_r[1] == rdy_s_r[2])
                rdy_r <= rdy_s_r[2];
            if (cgr_s_r[1] == cgr_s_r[2])
                cgr_r <= cgr_s_r[2];
            if (stb_s_r[1] == stb_s_r[2])
                stb_r <= stb_s_r[2];
        end
    end

    // ==========================================================
    // Power-on clear and processor reset timers
    // Clear must outlast the reset count, or the ready order breaks
    logic [POC_CNT_W-1:0] poc_cnt_r;
    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic                 poc_active_r;
    logic                 rst_active_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            poc_cnt_r    <= '0;
            poc_active_r <= 1'b1;
        end else if (poc_active_r) begin
            if (poc_cnt_r == POC_CNT_W'(POC_CYCLES - 1))
                poc_active_r <= 1'b0;
            else
                poc_cnt_r <= poc_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rst_cnt_r    <= '0;
            rst_active_r <= 1'b1;
        end else if (rst_active_r) begin
            if (rst_cnt_r == RST_CNT_W'(RESET_CYC - 1))
                rst_active_r <= 1'b0;
            else
                rst_cnt_r <= rst_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            power_on_clear_n <= 1'b0;
            cpu_reset        <= 1'b1;
        end else begin
            power_on_clear_n <= !poc_active_r;
            cpu_reset        <= rst_active_r;
        end
    end

    // ==========================================================
    // Two-phase clock, phi1 then phi2, never overlapping
    logic [PHI_CNT_W-1:0] phi_cnt_r;
    logic                 phase_r;
    logic                 phase_end;
    logic                 phi2_rise;

    assign phase_end = (phi_cnt_r == PHI_CNT_W'(PHI_HALF_CYC - 1));
    assign phi2_rise = phase_end && !phase_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            phi_cnt_r <= '0;
            phase_r   <= 1'b0;
        end else if (phase_end) begin
            phi_cnt_r <= '0;
            phase_r   <= !phase_r;
        end else begin
            phi_cnt_r <= phi_cnt_r + 1'b1;
        end
    end

    // One-cycle gap keeps the phases apart
    always_ff @(posedge clk) begin
        if (!resetn) begin
            phi1 <= 1'b0;
            phi2 <= 1'b0;
        end else begin
            phi1 <= !phase_r && !phase_end;
            phi2 <= phase_r && !phase_end;
        end
    end

    // ==========================================================
    // Panel counter on phase two, bit-13 tick
    logic [CNT_W-1:0] div_cnt_r;
    logic             tick;

    // Carry into bit 13 while it is low: one tick per bit-13 period
    assign tick = phi2_rise && !div_cnt_r[TICK_BIT] && (div_cnt_r[TICK_BIT-1:0] == '1);

    always_ff @(posedge clk) begin
        if (!resetn)
            div_cnt_r <= '0;
        else if (phi2_rise)
            div_cnt_r <= div_cnt_r + 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!resetn)
            counter_bit13_tick <= 1'b0;
        else
            counter_bit13_tick <= div_cnt_r[TICK_BIT];
    end

    // ==========================================================
    // Two-stage switch latches, clocked on the bit-13 rising edge
    logic [SW_W-1:0] sw_sync0_r;
    logic [SW_W-1:0] sw_sync1_r;
    logic [SW_W-1:0] sw_sync2_r;
    logic [SW_W-1:0] sw_filt_r;
    logic [SW_W-1:0] sw_stage1_qn_r;

    // Slow tick also debounces the switches
    generate
        for (genvar i = 0; i < SW_W; i++) begin : g_sw
            // Released switches read high, so the chain rests at one
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    sw_sync0_r[i] <= 1'b1;
                    sw_sync1_r[i] <= 1'b1;
                    sw_sync2_r[i] <= 1'b1;
                end else begin
                    sw_sync0_r[i] <= panel_switch_n[i];
                    sw_sync1_r[i] <= sw_sync0_r[i];
                    sw_sync2_r[i] <= sw_sync1_r[i];
                end
            end

            always_ff @(posedge clk) begin
                if (!resetn)
                    sw_filt_r[i] <= 1'b1;
                else if (sw_sync1_r[i] == sw_sync2_r[i])
                    sw_filt_r[i] <= sw_sync2_r[i];
            end

            always_ff @(posedge clk) begin
                if (!resetn)
                    sw_stage1_qn_r[i] <= 1'b1;
                else if (tick)
                    sw_stage1_qn_r[i] <= !sw_filt_r[i];
            end

            always_ff @(posedge clk) begin
                if (!resetn)
                    sw_stage2_q[i] <= 1'b0;
                else if (tick)
                    sw_stage2_q[i] <= sw_stage1_qn_r[i];
            end
        end
    endgenerate

    // ==========================================================
    // Panel control flip-flops under power-on clear
    always_ff @(posedge clk) begin
        if (!resetn)
            prom_addr_clear <= 1'b1;
        else
            prom_addr_clear <= poc_active_r;
    end

    // Nothing here sets single step, so clear is its only writer
    always_ff @(posedge clk) begin
        if (!resetn)
            single_step_en <= 1'b0;
        else if (poc_active_r)
            single_step_en <= 1'b0;
    end

    // Clear presets stopped and masks the run input until it ends
    always_ff @(posedge clk) begin
        if (!resetn)
            run_stopped <= 1'b1;
        else if (poc_active_r)
            run_stopped <= 1'b1;
        else if (cgr_r)
            run_stopped <= 1'b0;
    end

    // ==========================================================
    // Processor ready
    // Bus wait reaches ready a few cycles late through the synchroniser
    always_ff @(posedge clk) begin
        if (!resetn)
            cpu_ready <= 1'b0;
        else if (rst_active_r || poc_active_r)
            cpu_ready <= 1'b0;
        else
            cpu_ready <= cgr_r && rdy_r;
    end

    // ==========================================================
    // Outbound system bus
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sysbus       <= '0;
            bus_data_out <= '0;
        end else begin
            sysbus.addr <= cpu_addr;
            if (cpu_status_valid)
                sysbus.status <= cpu_status;
            if (cpu_data_oe) begin
                sysbus.data_out <= cpu_data_o;
                bus_data_out    <= cpu_data_o;
            end
        end
    end

    // ==========================================================
    // Inbound data selection, one source at a time
    // Data words skip the synchroniser; they settle before the strobe
    cbs_sel_t sel_nxt;

    always_comb begin
        sel_nxt = CBS_SEL_NONE;
        if (stb_r && !cpu_data_oe) begin
            if (bc_r)
                sel_nxt = CBS_SEL_PANEL;
            else
                sel_nxt = CBS_SEL_BUS;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cpu_data_i    <= '0;
            cpu_data_i_oe <= 1'b0;
        end else begin
            case (sel_nxt)
                CBS_SEL_BUS: begin
                    cpu_data_i    <= bus_data_in;
                    cpu_data_i_oe <= 1'b1;
                end
                CBS_SEL_PANEL: begin
                    cpu_data_i    <= panel_data_in;
                    cpu_data_i_oe <= 1'b1;
                end
                default: begin
                    cpu_data_i    <= '0;
                    cpu_data_i_oe <= 1'b0;
                end
            endcase
        end
    end

endmodule : cbs_cpu_glue

// [testbench/cbs_cpu_glue_asserts.sv]
module cbs_cpu_glue_asserts
    import cbs_pkg::*;
(
    // Watched ports
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic              data_in_strobe,
    input wire logic              cpu_data_i_oe,
    input wire logic              cpu_ready,
    input wire logic              cpu_reset,
    input wire cbs_sysbus_t       sysbus,
    input wire logic              bus_ready,
    input wire logic              phi1,
    input wire logic              phi2,
    input wire logic              power_on_clear_n,
    input wire logic              clock_gen_ready_input,
    input wire logic              single_step_en,
    input wire logic              run_stopped,
    input wire logic              prom_addr_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_addr_follow: assert property ($past(resetn) |-> sysbus.addr == $past(cpu_addr))
        else $error("address not forwarded");
    a_oe_cause: assert property ($rose(cpu_data_i_oe) |-> $past(data_in_strobe, 3))
        else $error("input drive without strobe");
    a_oe_release: assert property (!data_in_strobe [*8] |-> !cpu_data_i_oe)
        else $error("input drive outlasts strobe");
    a_wait_state: assert property (!bus_ready [*8] |-> !cpu_ready)
        else $error("ready despite bus wait");
    a_ready_gate: assert property (!clock_gen_ready_input [*8] |-> !cpu_ready)
        else $error("ready without ready input");
    a_ready_held: assert property (cpu_reset || !power_on_clear_n |-> !cpu_ready)
        else $error("ready during reset or clear");
    a_reset_first: assert property (power_on_clear_n |-> !cpu_reset)
        else $error("reset outlasts clear");
    a_clear_effects: assert property (!power_on_clear_n |->
        prom_addr_clear && run_stopped && !single_step_en)
        else $error("clear effects missing");
    a_phase_apart: assert property (!(phi1 && phi2))
        else $error("phases overlap");
    a_phase_gap: assert property ($rose(phi2) |-> $past(phi1, 2) && !$past(phi1))
        else $error("phase gap wrong");
endmodule : cbs_cpu_glue_asserts

bind cbs_cpu_glue cbs_cpu_glue_asserts cbs_cpu_glue_asserts_i (.clk(clk), .resetn(resetn),
    .cpu_addr(cpu_addr), .data_in_strobe(data_in_strobe), .cpu_data_i_oe(cpu_data_i_oe),
    .cpu_ready(cpu_ready), .cpu_reset(cpu_reset), .sysbus(sysbus), .bus_ready(bus_ready),
    .phi1(phi1), .phi2(phi2), .power_on_clear_n(power_on_clear_n),
    .clock_gen_ready_input(clock_gen_ready_input), .single_step_en(single_step_en),
    .run_stopped(run_stopped), .prom_addr_clear(prom_addr_clear));

// [testbench/cbs_far_side.sv]
module cbs_far_side
    import cbs_pkg::*;
(
    // Bus side
    input  wire logic              clk,
    input  wire logic              power_on_clear_n,
    input  wire cbs_sysbus_t       sysbus,
    input  wire logic [DATA_W-1:0] bus_data_out,
    output logic      [DATA_W-1:0] bus_data_in,
    output logic                   bus_ready,
    // Panel side
    input  wire logic              slow,
    input  wire logic              panel_take,
    output logic                   panel_bus_control,
    output logic      [DATA_W-1:0] panel_data_in,
    output logic      [DATA_W-1:0] shown_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] hold_r;
    // ==========================================================
    // Cards; released lines toggle so stale data never passes
    always_ff @(posedge clk) begin
        if (!power_on_clear_n) begin
            hold_r      <= 6'h00;
            bus_ready   <= 1'b1;
            bus_data_in <= 8'h00;
        end else begin
            hold_r      <= {hold_r[4:0], slow};
            bus_ready   <= ~|{hold_r, slow};
            bus_data_in <= sysbus.status[0] ? sysbus.addr[7:0] ^ 8'h5a : ~bus_data_in;
        end
    end
    // ==========================================================
    // Panel
    always_ff @(posedge clk) begin
        panel_bus_control <= panel_take;
        panel_data_in     <= panel_take ? 8'ha7 : ~panel_data_in;
        shown_r           <= bus_data_out;
    end
endmodule : cbs_far_side

// [testbench/cbs_cpu_glue_tb.sv]
module cbs_cpu_glue_tb
    import cbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin \
    check_count++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("ERROR %s exp %h got %h", n, e, g); \
    end \
end
`define WAITF(c) begin \
    for (int w = 0; w < 80 && !(c); w++) @(negedge clk); \
    if (!(c)) give_up(); \
end
    // Shortened clear so the run stays brief; must exceed reset count
    localparam int POCC = 5000;
    logic clk = 1'b0, resetn = 1'b0, oe, strobe = 1'b0, rdy_in = 1'b0, slow = 1'b0;
    logic take = 1'b0, i_oe, ready, rst, b_rdy, phi1, phi2, poc_n, ctl, tick, step, stop, prom;
    logic [ADDR_W-1:0] addr = 16'h0000;
    logic [DATA_W-1:0] d_o = 8'h00, d_i, d_out, d_in, p_in, shown;
    logic [STAT_W-1:0] stat = 8'h00;
    logic              stat_v = 1'b0;
    logic [SW_W-1:0]   sw2;
    cbs_sysbus_t       sysbus;
    int                bad_count = 0, check_count = 0;
    always #5 clk = ~clk;
    cbs_cpu_glue #(.POC_CYCLES(POCC)) cbs_cpu_glue_i (.clk(clk), .resetn(resetn),
        .cpu_addr(addr), .cpu_status(stat), .cpu_status_valid(stat_v), .cpu_data_o(d_o),
        .cpu_data_oe(oe), .cpu_data_i(d_i), .cpu_data_i_oe(i_oe), .data_in_strobe(strobe),
        .cpu_ready(ready), .cpu_reset(rst), .sysbus(sysbus), .bus_data_out(d_out),
        .bus_data_in(d_in), .bus_ready(b_rdy), .phi1(phi1), .phi2(phi2),
        .power_on_clear_n(poc_n), .panel_bus_control(ctl), .panel_data_in(p_in),
        .panel_switch_n(16'hffff), .clock_gen_ready_input(rdy_in),
        .counter_bit13_tick(tick), .sw_stage2_q(sw2), .single_step_en(step),
        .run_stopped(stop), .prom_addr_clear(prom));
    cbs_far_side cbs_far_side_i (.clk(clk), .power_on_clear_n(poc_n), .sysbus(sysbus),
        .bus_data_out(d_out), .bus_data_in(d_in), .bus_ready(b_rdy), .slow(slow),
        .panel_take(take), .panel_bus_control(ctl), .panel_data_in(p_in), .shown_r(shown));
    // ==========================================================
    // Scenarios
    task automatic power_up;
        int n;
        n = 0;
        while (rst === 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 9000) give_up();
        `CHK("reset len", RESET_CYC + 1, n)
        `CHK("clear", 1'b0, poc_n)
        `CHK("prom clr", 1'b1, prom)
        `CHK("stopped", 1'b1, stop)
        `CHK("step", 1'b0, step)
        `CHK("ready", 1'b0, ready)
        while (poc_n !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 9000) give_up();
        `CHK("clear len", POCC + 1, n)
        // Tick needs far more cycles than the run allows
        `CHK("tick", 1'b0, tick)
        `CHK("stage2", 16'h0000, sw2)
    endtask : power_up
    task automatic read_cycle(input logic [ADDR_W-1:0] a, input logic pan);
        take = pan;
        addr = a;
        stat = 8'h01;
        stat_v = 1'b1;
        repeat (6) @(negedge clk);
        `CHK("addr", a, sysbus.addr)
        `CHK("status", 8'h01, sysbus.status)
        strobe = 1'b1;
        `WAITF(i_oe === 1'b1)
        `CHK("data in", pan ? 8'ha7 : a[7:0] ^ 8'h5a, d_i)
        strobe = 1'b0;
        stat_v = 1'b0;
        `WAITF(i_oe === 1'b0)
        `CHK("oe off", 1'b0, i_oe)
        take = 1'b0;
        @(negedge clk);
    endtask : read_cycle
    task automatic t_write;
        d_o = 8'hc3;
        oe = 1'b1;
        strobe = 1'b1;
        repeat (10) @(negedge clk);
        `CHK("data out", 8'hc3, d_out)
        `CHK("bus data", 8'hc3, sysbus.data_out)
        `CHK("shown", 8'hc3, shown)
        `CHK("refused", 1'b0, i_oe)
        // Strobe settles through its synchroniser before the drive ends
        strobe = 1'b0;
        repeat (6) @(negedge clk);
        oe = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("no drive", 1'b0, i_oe)
    endtask : t_write
    task automatic t_ready;
        slow = 1'b1;
        repeat (8) @(negedge clk);
        rdy_in = 1'b1;
        repeat (12) @(negedge clk);
        `CHK("wait", 1'b0, ready)
        `CHK("run", 1'b0, stop)
        slow = 1'b0;
        `WAITF(ready === 1'b1)
        `CHK("ready", 1'b1, ready)
        slow = 1'b1;
        `WAITF(ready === 1'b0)
        `CHK("hold", 1'b0, ready)
        slow = 1'b0;
    endtask : t_ready
    task automatic give_up;
        bad_count++;
        $display("ERROR wait expired");
        report_and_stop();
    endtask : give_up
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        oe = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        power_up();
        read_cycle(16'h12c4, 1'b0);
        read_cycle(16'h0e3b, 1'b1);
        t_write();
        t_ready();
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule : cbs_cpu_glue_tb
